// ==== hw/twc_core.sv ====
// Two-wire bus channel: wait timing, start/stop/acknowledge signalling, address match and shifting.
// Assumes one AHB-Lite master, pull-ups on both lines, and open-drain pads resolved outside.
//
// Functional notes
// R1 - Wait code 00: flag on rise of 8th clock, clock left released.
// R2 - Wait code 10: flag on 8th rise, then hold clock low.
// R3 - Wait code 11: flag on 9th rise, then hold clock low after acknowledge clock.
// R4 - Software uses only wait codes 10 or 11 in bus mode.
// R5 - Writing wait release ends the wait and self-clears; reads 0 when released.
// R6 - Outside transfers, clock level 0 pulls clock low, 1 releases it; the code pulls it low only with internal clock and a wait code other than 00.
// R7 - Address width bit 1 compares bits 7..1 only, else all bits.
// R8 - Interrupt source bit 1 also sets the flag on stop detection.
// R9 - Clock level status mirrors clock pin, zero when channel disabled.
// R10 - Timing register resets to 00h, bit 7 reads zero.
// R11 - Start: data falls while clock high; sets start detected flag.
// R12 - Stop: data rises while clock high; sets stop, clears start flag.
// R13 - Receiver acknowledges with data low one clock; transmitter sets ack flag.
// R14 - Master sends 7-bit address, direction bit, then 8-bit data bytes.
// R15 - With wake-up, flag only on address match or stop detection.
// R16 - Shift out MSB first on falling edges, sample on rising edges.
// R17 - The transmitter captures actual data line into its shift register.
// R18 - Shift write starts transfer only when enabled and clock stopped or low.
// R19 - Shift write during wait is held; starts after wait release.
// R20 - Transfer end stops shifting and sets the interrupt flag.
// R21 - Busy ends on transfer start or address reception; control bit stays.
// R22 - Software sets output disable and writes FFh before receiving.
// R23 - Start trigger clears output latch, stop trigger sets it; both self-clear.
// R24 - Pins only pull low or release, never drive high.
`timescale 1ns/1ps
`default_nettype none

module twc_core
  import twc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             channel_interrupt_out
);

  // ----------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------
  logic        ap_vld_q;
  logic        ap_wr_q;
  logic [15:0] ap_idx_q;
  logic [31:0] hrdata_q;
  logic [7:0]  rd_byte;
  logic [7:0]  wdat;

  function automatic logic hit(input logic [15:0] idx);
    hit = ap_vld_q && ap_wr_q && (ap_idx_q == idx);
  endfunction

  assign wdat          = hwdata_in[7:0];
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ap_vld_q <= 1'b0;
      ap_wr_q  <= 1'b0;
      ap_idx_q <= 16'h0000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ap_vld_q <= hsel_in && htrans_in[1] && hready_in;
      ap_wr_q  <= hwrite_in;
      ap_idx_q <= haddr_in[17:2];
      if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and line events.
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic scl_rise, scl_fall, start_evt, stop_evt;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
    end
  end

  assign scl_rise  = scl_s_q && !scl_p_q;
  assign scl_fall  = !scl_s_q && scl_p_q;
  assign start_evt = scl_s_q && scl_p_q && !sda_s_q && sda_p_q; // R11
  assign stop_evt  = scl_s_q && scl_p_q && sda_s_q && !sda_p_q; // R12

  // ----------------------------------------------------------------
  // Software registers.
  // ----------------------------------------------------------------
  logic       en_q, wup_q, iclk_q;
  logic       odis_q, ack_auto_enable_q, ack_trigger_bit_q, stao_q, stoo_q;
  logic       src_q, aw_q, clc_q, wait_release_bit_q;
  logic [1:0] wsel_q;
  logic [7:0] sva_q;
  logic       match, clock_level_status;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      {en_q, wup_q, iclk_q} <= 3'h0;
      {src_q, aw_q, clc_q}  <= 3'h0;
      wsel_q                <= TWC_ITC_RST[1:0]; // R10
      sva_q                 <= TWC_BYTE_RST;
      {odis_q, ack_auto_enable_q}      <= 2'h0;
    end else begin
      if (hit(TWC_IDX_MODE)) begin
        en_q   <= wdat[TWC_MODE_EN];
        wup_q  <= wdat[TWC_MODE_WUP];
        iclk_q <= wdat[TWC_MODE_ICLK];
      end
      if (hit(TWC_IDX_ITC)) begin
        src_q  <= wdat[TWC_ITC_SRC];
        aw_q   <= wdat[TWC_ITC_AW];
        clc_q  <= wdat[TWC_ITC_CLC];
        wsel_q <= wdat[1:0];
      end
      if (hit(TWC_IDX_BIC)) begin
        odis_q <= wdat[TWC_BIC_ODIS];
        ack_auto_enable_q <= wdat[TWC_BIC_ACK_AUTO_ENABLE];
      end
      if (hit(TWC_IDX_SVA)) begin
        sva_q <= wdat;
      end
    end
  end

  // One-cycle triggers; each reads back as zero once it has acted.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      {stao_q, stoo_q, wait_release_bit_q} <= 3'h0;
    end else begin
      stao_q <= en_q && hit(TWC_IDX_BIC) && wdat[TWC_BIC_STAO]; // R23
      stoo_q <= en_q && hit(TWC_IDX_BIC) && wdat[TWC_BIC_STOO]; // R23
      wait_release_bit_q <= hit(TWC_IDX_ITC) && wdat[TWC_ITC_WAIT_RELEASE_BIT];          // R5
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencing.
  // ----------------------------------------------------------------
  twc_xfer_t  st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       pend_q, wake_q, adr_chk_q, after8_q;
  logic       sh_wr, start_ok, go, xfer_end;
  logic [3:0] last_bit;

  assign sh_wr    = hit(TWC_IDX_SHIFT);
  assign start_ok = en_q && (st_q == TWC_IDLE) && (iclk_q || !scl_s_q); // R18
  assign go       = (sh_wr && start_ok) || (pend_q && start_ok);         // R19
  assign last_bit = (wsel_q == TWC_WAIT_9) ? TWC_BITS_9 : TWC_BITS_8; // R3 R14
  assign xfer_end = (st_q == TWC_RUN) && scl_rise && (cnt_q + 4'h1 == last_bit);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_q   <= TWC_IDLE;
      cnt_q  <= 4'h0;
      pend_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (!en_q) begin
      st_q   <= TWC_IDLE;
      pend_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      if (sh_wr && st_q == TWC_HOLD) begin
        pend_q <= 1'b1; // R19
      end else if (go) begin
        pend_q <= 1'b0;
      end
      case (st_q)
        TWC_IDLE: begin
          if (go) begin
            st_q  <= TWC_RUN;
            cnt_q <= 4'h0;
          end else if (start_evt && wup_q) begin
            st_q   <= TWC_RUN; // R15
            cnt_q  <= 4'h0;
            wake_q <= 1'b1;
          end
        end
        TWC_RUN: begin
          if (xfer_end) begin
            st_q   <= (wsel_q == TWC_WAIT_NONE) ? TWC_IDLE : TWC_TAIL; // R1 R20
            wake_q <= 1'b0;
          end else if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        TWC_TAIL: begin
          if (scl_fall) begin
            st_q <= TWC_HOLD; // R2 R3
          end
        end
        TWC_HOLD: begin
          if (wait_release_bit_q) begin
            st_q <= TWC_IDLE; // R5
          end
        end
        default: st_q <= TWC_IDLE;
      endcase
    end
  end

  // Shift register: software load, sampling on rises and capture of the real line.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sh_q <= TWC_BYTE_RST;
    end else if (sh_wr) begin
      sh_q <= wdat;
    end else if (st_q == TWC_RUN && scl_rise && cnt_q < TWC_BITS_8) begin
      sh_q <= {sh_q[6:0], sda_s_q}; // R16 R17
    end
  end

  // ----------------------------------------------------------------
  // Condition and acknowledge flags.
  // ----------------------------------------------------------------
  logic stad_q, stod_q, ack_detected_flag_q, flag_q, busy_q;
  logic ack_drv_q, ack_rose_q, latch_q;
  logic flag_set;

  assign match    = en_q && (aw_q ? (sh_q[7:1] == sva_q[7:1]) : (sh_q == sva_q)); // R7
  assign clock_level_status      = en_q && scl_s_q;                                              // R9
  assign flag_set = (xfer_end && !wup_q)                                          // R1 R2 R3 R20
                  || (adr_chk_q && match)                                         // R15
                  || (stop_evt && en_q && (src_q || wup_q));                      // R8

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      {adr_chk_q, after8_q} <= 2'h0;
    end else begin
      adr_chk_q <= xfer_end && wake_q;
      if (st_q == TWC_RUN && scl_rise && cnt_q == 4'h7) begin
        after8_q <= 1'b1;
      end else if (scl_rise || !en_q) begin
        after8_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in || !en_q) begin
      {stad_q, stod_q, ack_detected_flag_q} <= 3'h0;
    end else begin
      if (start_evt) begin
        stad_q <= 1'b1; // R11
      end else if (stop_evt || go) begin
        stad_q <= 1'b0; // R12
      end
      if (stop_evt) begin
        stod_q <= 1'b1; // R12
      end else if (go || (adr_chk_q && !match)) begin
        stod_q <= 1'b0;
      end
      if (after8_q && scl_rise && !sda_s_q) begin
        ack_detected_flag_q <= 1'b1; // R13
      end else if (go) begin
        ack_detected_flag_q <= 1'b0;
      end
    end
  end

  // The set term wins over a clear that lands in the same cycle.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (hit(TWC_IDX_FLAG) && wdat[0]) begin
      flag_q <= 1'b0;
    end
  end

  assign channel_interrupt_out = flag_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      busy_q <= 1'b0;
    end else if (hit(TWC_IDX_BIC) && wdat[TWC_BIC_ODIS]) begin
      busy_q <= 1'b1;
    end else if (go || adr_chk_q || (hit(TWC_IDX_BIC) && !wdat[TWC_BIC_ODIS])) begin
      busy_q <= 1'b0; // R21
    end
  end

  // Acknowledge drive: automatic on the ninth clock, or by software trigger until the fall that follows the next rise.
  always_ff @(posedge core_clk_in) begin
    if (srst_in || !en_q) begin
      {ack_drv_q, ack_rose_q, ack_trigger_bit_q} <= 3'h0;
    end else begin
      ack_trigger_bit_q <= hit(TWC_IDX_BIC) && wdat[TWC_BIC_ACK_TRIGGER_BIT];
      if (ack_trigger_bit_q || (ack_auto_enable_q && after8_q && scl_fall)) begin
        ack_drv_q  <= 1'b1; // R13
        ack_rose_q <= 1'b0;
      end else if (ack_drv_q && scl_rise) begin
        ack_rose_q <= 1'b1;
      end else if (ack_drv_q && ack_rose_q && scl_fall) begin
        ack_drv_q <= 1'b0;
      end
    end
  end

  // Serial output latch: MSB first on falls, released for the acknowledge slot with wait code 11.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      latch_q <= 1'b1;
    end else if (stao_q) begin
      latch_q <= 1'b0; // R23
    end else if (stoo_q) begin
      latch_q <= 1'b1; // R23
    end else if (go) begin
      latch_q <= sh_wr ? wdat[7] : sh_q[7]; // R16
    end else if (st_q == TWC_RUN && scl_fall) begin
      latch_q <= (cnt_q < TWC_BITS_8) ? sh_q[7] : 1'b1; // R16
    end
  end

  // ----------------------------------------------------------------
  // Internal clock generator with stretch detection.
  // ----------------------------------------------------------------
  logic       gen_low_q;
  logic [7:0] gcnt_q;
  logic       gen_run;

  // The generator keeps running in the tail so that its low phase pulls the clock down into the wait.
  assign gen_run = en_q && iclk_q && (st_q == TWC_RUN || st_q == TWC_TAIL); // R2 R3

  always_ff @(posedge core_clk_in) begin
    if (srst_in || !gen_run) begin
      gen_low_q <= 1'b1;
      gcnt_q    <= 8'h00;
    end else if (!gen_low_q && !scl_s_q) begin
      gcnt_q <= 8'h00;
    end else if (gcnt_q == TWC_HALF_CYC - 8'h01) begin
      gcnt_q    <= 8'h00;
      gen_low_q <= !gen_low_q;
    end else begin
      gcnt_q <= gcnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drive and read-back.
  // ----------------------------------------------------------------
  assign scl_out    = 1'b0; // R24
  assign sda_out    = 1'b0; // R24
  assign scl_oe_out = en_q && ((st_q == TWC_HOLD)                                // R2 R3
                    || (gen_run && gen_low_q)
                    || (iclk_q && st_q == TWC_IDLE && !clc_q && wsel_q != TWC_WAIT_NONE)); // R6
  assign sda_oe_out = en_q && (ack_drv_q || (!busy_q && !wup_q && !latch_q));

  always_comb begin
    rd_byte = 8'h00;
    case (haddr_in[17:2])
      TWC_IDX_MODE:  rd_byte = {en_q, match, wup_q, 3'h0, iclk_q, 1'b0};
      TWC_IDX_BIC:   rd_byte = {odis_q, ack_detected_flag_q, ack_auto_enable_q, 1'b0, stad_q, stod_q, 2'h0};
      TWC_IDX_ITC:   rd_byte = {1'b0, clock_level_status, src_q, aw_q, clc_q, wait_release_bit_q, wsel_q}; // R10
      TWC_IDX_SHIFT: rd_byte = sh_q;
      TWC_IDX_SVA:   rd_byte = sva_q;
      TWC_IDX_FLAG:  rd_byte = {7'h00, flag_q};
      default:       rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence hold_seq;
    (st_q == TWC_HOLD) ##0 scl_oe_out;
  endsequence

  wait8_flag_a: assert property (xfer_end && wsel_q == TWC_WAIT_8 && !wup_q |=> flag_q ##0 st_q == TWC_TAIL) // R2
    else $error("8-clock end did not flag");
  wait9_hold_a: assert property (st_q == TWC_TAIL && scl_fall && en_q |=> hold_seq) // R3
    else $error("clock not held low after transfer");
  wait0_idle_a: assert property (xfer_end && wsel_q == TWC_WAIT_NONE && en_q |=> st_q == TWC_IDLE) // R1
    else $error("no-wait mode entered wait");
  wait_release_bit_done_a: assert property (wait_release_bit_q && st_q == TWC_HOLD && en_q |=> st_q == TWC_IDLE ##1 !scl_oe_out || st_q != TWC_HOLD) // R5
    else $error("wait release ignored");
  cld_off_a: assert property (!en_q |-> !clock_level_status && !scl_oe_out && !sda_oe_out) // R9
    else $error("disabled channel shows clock level");
  stop_flags_a: assert property (stop_evt && en_q |=> stod_q && !stad_q) // R12
    else $error("stop flags wrong");
  stop_irq_a: assert property (stop_evt && en_q && src_q && !(hit(TWC_IDX_FLAG) && wdat[0]) |=> flag_q) // R8
    else $error("stop did not set flag");
  start_trig_a: assert property (stao_q |=> !latch_q && !stao_q) // R23
    else $error("start trigger did not clear latch");
  msb_out_a: assert property (st_q == TWC_RUN && scl_fall && cnt_q < TWC_BITS_8 && !stao_q && !stoo_q // R16
                              |=> latch_q == $past(sh_q[7]))
    else $error("serial output not MSB first");
  no_start_a: assert property (sh_wr && !en_q && st_q == TWC_IDLE |=> st_q == TWC_IDLE) // R18
    else $error("transfer started while disabled");
  busy_end_a: assert property (go && !hit(TWC_IDX_BIC) |=> !busy_q ##0 st_q == TWC_RUN) // R21
    else $error("busy not ended at transfer start");

endmodule // twc_core

`default_nettype wire

// ==== hw/twc_pkg.sv ====
// Constants, register map and types of the two-wire bus wait and condition controller.
// Assumes a 100 MHz core clock and word-wide AHB-Lite access to the register file.
package twc_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [15:0] TWC_IDX_MODE  = 16'hff60;
  localparam logic [15:0] TWC_IDX_BIC   = 16'hff61;
  localparam logic [15:0] TWC_IDX_ITC   = 16'hff63;
  localparam logic [15:0] TWC_IDX_SHIFT = 16'hff64;
  localparam logic [15:0] TWC_IDX_SVA   = 16'hff65;
  localparam logic [15:0] TWC_IDX_FLAG  = 16'hff66;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int TWC_MODE_EN    = 7;
  localparam int TWC_MODE_MATCH = 6;
  localparam int TWC_MODE_WUP   = 5;
  localparam int TWC_MODE_ICLK  = 1;
  localparam int TWC_BIC_ODIS   = 7;
  localparam int TWC_BIC_ACK_DETECTED_FLAG   = 6;
  localparam int TWC_BIC_ACK_AUTO_ENABLE   = 5;
  localparam int TWC_BIC_ACK_TRIGGER_BIT   = 4;
  localparam int TWC_BIC_STAD   = 3;
  localparam int TWC_BIC_STOD   = 2;
  localparam int TWC_BIC_STAO   = 1;
  localparam int TWC_BIC_STOO   = 0;
  localparam int TWC_ITC_CLD    = 6;
  localparam int TWC_ITC_SRC    = 5;
  localparam int TWC_ITC_AW     = 4;
  localparam int TWC_ITC_CLC    = 3;
  localparam int TWC_ITC_WAIT_RELEASE_BIT   = 2;

  // ----------------------------------------------------------------
  // Reset values, wait codes and counts.
  // ----------------------------------------------------------------
  localparam logic [7:0] TWC_ITC_RST   = 8'h00;
  localparam logic [7:0] TWC_BYTE_RST  = 8'h00;
  localparam logic [1:0] TWC_WAIT_NONE = 2'h0;
  localparam logic [1:0] TWC_WAIT_8    = 2'h2;
  localparam logic [1:0] TWC_WAIT_9    = 2'h3;
  localparam logic [3:0] TWC_BITS_8    = 4'h8;
  localparam logic [3:0] TWC_BITS_9    = 4'h9;

  localparam int TWC_CLK_MHZ     = 100;
  localparam int TWC_SCL_HALF_NS = 500;
  localparam int TWC_HALF_CYC_I  = (TWC_SCL_HALF_NS * TWC_CLK_MHZ) / 1000;
  localparam logic [7:0] TWC_HALF_CYC = 8'(TWC_HALF_CYC_I < 1 ? 1 : TWC_HALF_CYC_I);

  typedef enum logic [1:0] {TWC_IDLE, TWC_RUN, TWC_TAIL, TWC_HOLD} twc_xfer_t;

endpackage

// ==== tb/tb_two_wire_bus_wait_and_condition_control.sv ====
// Self-checking bench: registers over AHB-Lite, master and wake-up slave transfers.
// Assumes twc_peer on the far side and pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none

module tb_two_wire_bus_wait_and_condition_control
  import twc_pkg::*;
;
  logic        core_clk, srst, hsel, hwrite, clr, ack_en, hrdy, irq;
  logic        scl, sda, d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, ack_dly;
  logic [7:0]  rx_byte, n_rise, b, slave_address_register;
  int          fails, n_checks, seed;
  logic [7:0]  exp_q[$];

  // Wired-AND lines with pull-ups.
  assign scl = !(d_scl_oe | p_scl_oe);
  assign sda = !(d_sda_oe | p_sda_oe);

  twc_core u_dut (.core_clk_in(core_clk), .srst_in(srst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(), .scl_in(scl), .scl_out(),
    .scl_oe_out(d_scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(d_sda_oe),
    .channel_interrupt_out(irq));

  twc_peer u_peer (.scl_in(scl), .sda_in(sda), .clr_in(clr), .ack_en_in(ack_en),
    .ack_dly_in(ack_dly), .scl_oe_out(p_scl_oe), .sda_oe_out(p_sda_oe),
    .rx_byte_out(rx_byte), .n_rise_out(n_rise));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_byte();
    logic [7:0] e;
    e = exp_q.pop_front();
    chk_val("peer byte", {24'h00_0000, e}, {24'h00_0000, rx_byte});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [31:0] rv);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {14'h0000, idx, 2'h0};
    hwrite <= w;
    do @(posedge core_clk); while (hrdy !== 1'h1);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hwdata <= {24'h00_0000, wd};
    do @(posedge core_clk); while (hrdy !== 1'h1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [31:0] unused;
    bus(1'h1, idx, v, unused);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] v;
    bus(1'h0, idx, 8'h00, v);
    chk_val(what, {24'h00_0000, e}, v & {24'hff_ffff, m});
  endtask

  task automatic clr_peer();
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
  endtask

  initial begin
    cyc(40000);
    fails++;
    $display("MISMATCH watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    seed = 32'hbe71;
    {fails, n_checks} = '0;
    {srst, clr, hsel, hwrite, ack_en} = 5'h19;
    {htrans, haddr, hwdata, ack_dly} = '0;
    cyc(3);
    {srst, clr} <= 2'h0;
    cyc(1);
    rd_chk("itc reset", TWC_IDX_ITC, 8'hff, TWC_ITC_RST);
    wr(TWC_IDX_ITC, 8'hb8);
    rd_chk("itc bits", TWC_IDX_ITC, 8'hff, 8'h38);
    rd_chk("unmapped", 16'hff62, 8'hff, 8'h00);
    wr(TWC_IDX_MODE, 8'h82);
    wr(TWC_IDX_ITC, 8'h03);
    cyc(8);
    chk_val("scl idle low", 32'h1, 32'(d_scl_oe));
    rd_chk("clock level low", TWC_IDX_ITC, 8'h40, 8'h00);
    wr(TWC_IDX_ITC, 8'h2b);
    cyc(8);
    chk_val("scl released", 32'h0, 32'(d_scl_oe));
    rd_chk("clock level high", TWC_IDX_ITC, 8'h40, 8'h40);
    $display("test clock level done");
    wr(TWC_IDX_BIC, 8'h01);
    cyc(8);
    wr(TWC_IDX_BIC, 8'h02);
    cyc(8);
    chk_val("sda start", 32'h1, 32'(d_sda_oe));
    rd_chk("start flag", TWC_IDX_BIC, 8'h0f, 8'h08);
    wr(TWC_IDX_BIC, 8'h01);
    cyc(8);
    chk_val("sda stop", 32'h0, 32'(d_sda_oe));
    rd_chk("stop flag", TWC_IDX_BIC, 8'h0f, 8'h04);
    chk_val("stop irq", 32'h1, 32'(irq));
    wr(TWC_IDX_FLAG, 8'h01);
    rd_chk("flag cleared", TWC_IDX_FLAG, 8'h01, 8'h00);
    $display("test conditions done");
    for (int w = 3; w >= 0; w -= (w == 2) ? 2 : 1) begin
      wr(TWC_IDX_ITC, 8'(w));
      ack_en <= (w == 3);
      ack_dly <= 32'($unsigned($random(seed)) % 300);
      clr_peer();
      b = 8'($random(seed));
      exp_q.push_back(b);
      wr(TWC_IDX_SHIFT, b);
      for (int k = 0; k < 3000 && irq !== 1'h1; k++) cyc(1);
      chk_val("rises at irq", 32'((w == 3) ? 9 : 8), 32'(n_rise));
      cyc(200);
      chk_val("rises held", 32'((w == 3) ? 9 : 8), 32'(n_rise));
      chk_val("scl held", 32'(w != 0), 32'(d_scl_oe));
      chk_byte();
      rd_chk("shift echo", TWC_IDX_SHIFT, 8'hff, b);
      if (w == 3) rd_chk("ack flag", TWC_IDX_BIC, 8'h40, 8'h40);
      wr(TWC_IDX_ITC, 8'(w) | 8'h04);
      cyc(4);
      rd_chk("wait released", TWC_IDX_ITC, 8'h04, 8'h00);
      wr(TWC_IDX_FLAG, 8'h01);
      $display("test master wait %0d done", w);
    end
    wr(TWC_IDX_MODE, 8'h00);
    wr(TWC_IDX_SHIFT, 8'h5a);
    wr(TWC_IDX_MODE, 8'h82);
    cyc(8);
    clr_peer();
    cyc(400);
    chk_val("no late start", 32'h0, 32'(n_rise));
    chk_val("no late irq", 32'h0, 32'(irq));
    $display("test late enable done");
    wr(TWC_IDX_MODE, 8'ha0);
    wr(TWC_IDX_BIC, 8'h80);
    slave_address_register = 8'($random(seed)) & 8'hfe;
    wr(TWC_IDX_SVA, slave_address_register);
    for (int c = 0; c < 3; c++) begin
      wr(TWC_IDX_ITC, (c == 1) ? 8'h33 : 8'h23);
      cyc(10);
      #2 u_peer.m_start();
      u_peer.m_byte(slave_address_register | 8'(c != 0));
      cyc(20);
      chk_val("address irq", 32'(c != 2), 32'(irq));
      wr(TWC_IDX_ITC, (c == 1) ? 8'h37 : 8'h27);
      wr(TWC_IDX_FLAG, 8'h01);
      #2 u_peer.m_stop();
      cyc(20);
      chk_val("stop irq", 32'h1, 32'(irq));
      wr(TWC_IDX_FLAG, 8'h01);
    end
    $display("test wake-up done");
    stop_test();
  end
endmodule // tb_two_wire_bus_wait_and_condition_control

`default_nettype wire

// ==== tb/twc_peer.sv ====
// Peer on the two-wire bus: an acknowledging slave plus master tasks.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module twc_peer (
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        clr_in,
  input  wire logic        ack_en_in,
  input  wire logic [31:0] ack_dly_in,
  output logic             scl_oe_out,
  output logic             sda_oe_out,
  output logic [7:0]       rx_byte_out,
  output logic [7:0]       n_rise_out
);
  logic [7:0] sh_q;
  logic       sl_oe_q;
  logic       m_sda_q;
  logic       m_scl_q;

  initial begin
    sl_oe_q = 1'h0;
    m_sda_q = 1'h0;
    m_scl_q = 1'h0;
    sh_q = 8'h00;
  end

  // Lines are only pulled low or released.
  assign scl_oe_out = m_scl_q;
  assign sda_oe_out = sl_oe_q | m_sda_q;

  always @(posedge scl_in or posedge clr_in) begin
    if (clr_in) begin
      n_rise_out <= 8'h00;
    end else begin
      sh_q <= {sh_q[6:0], sda_in};
      if (n_rise_out == 8'h07) begin
        rx_byte_out <= {sh_q[6:0], sda_in};
      end
      n_rise_out <= n_rise_out + 8'h01;
    end
  end

  // The acknowledge may come late within the low phase.
  always @(negedge scl_in) begin
    if (ack_en_in && n_rise_out == 8'h08) begin
      #(ack_dly_in);
      sl_oe_q = 1'h1;
    end else begin
      sl_oe_q = 1'h0;
    end
  end

  task m_start();
    m_sda_q = 1'h1;
    #40 m_scl_q = 1'h1;
  endtask

  task m_bit(input logic b);
    #15 m_sda_q = !b;
    #25 m_scl_q = 1'h0;
    wait (scl_in === 1'h1);
    #40 m_scl_q = 1'h1;
  endtask

  task m_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      m_bit(v[i]);
    end
    m_bit(1'h1);
  endtask

  task m_stop();
    #15 m_sda_q = 1'h1;
    #25 m_scl_q = 1'h0;
    wait (scl_in === 1'h1);
    #40 m_sda_q = 1'h0;
    #40;
  endtask
endmodule // twc_peer

`default_nettype wire
